/* File: rtl/reset_ctrl_pkg.sv */
/*
  Shared constants of the system reset controller: register offsets, field
  positions, reset values, state encoding and timing counts.
  Assumes a single 250 MHz clock and an Avalon-MM register slave.
*/
package reset_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] OFS_WDT_CTRL = 8'h00;
  localparam logic [7:0] OFS_VDET_MODE = 8'h04;
  localparam logic [7:0] OFS_SRC_FLAGS = 8'h08;
  localparam logic [7:0] OFS_DEBUG_MODE = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  ////////////////////////////////////////////////////////////////////////////
  // fields
  localparam int WDT_MODE_BIT = 0;
  localparam int CPU_DIV_LSB = 1;
  localparam logic [1:0] CPU_DIV_RESET = 2'h3;
  localparam int VDET_SELECT_BIT = 0;
  localparam int VDET_ENABLE_BIT = 7;
  localparam int FLAG_VDET_BIT = 0;
  localparam int FLAG_CLKMON_BIT = 1;
  localparam int FLAG_WDT_BIT = 4;
  localparam logic [7:0] SRC_FLAGS_RESET = 8'h00;
  localparam logic [7:0] DEBUG_MODE_RESET = 8'h01;
  localparam int ST_SYSRST_BIT = 0;
  localparam int ST_CPURUN_BIT = 1;
  localparam int ST_POWERON_BIT = 2;
  localparam int ST_RAMLOST_BIT = 3;
  localparam int ST_VLOW_BIT = 4;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int WDT_RESET_DELAY_NS = 200;
  localparam int WDT_RESET_CYCLES = (WDT_RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAB_EXP = 16;
  localparam int STAB_CYCLES_DEFAULT = 2 ** STAB_EXP;
  localparam int CNT_W = 18;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_PIN,
    ST_WDT,
    ST_LVI,
    ST_STAB
  } state_type;

endpackage : reset_ctrl_pkg

/* File: rtl/reset_input_sync.sv */
/*
  Three-flop input synchroniser with a two-flop agreement filter per bit.
  Assumes inputs are asynchronous levels; output changes only when the
  second and third stages agree.
*/
`timescale 1ns/10ps
module reset_input_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      logic s3_r;
      // s1 feeds s2 only: metastability stays in the first stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r <= RESET_VAL[i];
          s2_r <= RESET_VAL[i];
          s3_r <= RESET_VAL[i];
          syncOut[i] <= RESET_VAL[i];
        end else begin
          s1_r <= asyncIn[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            syncOut[i] <= s3_r;
          end
        end
      end
    end
  endgenerate

endmodule : reset_input_sync

/* File: rtl/system_reset_controller.sv */
/*
  System reset controller: combines pin, watchdog, clock-monitor and
  low-voltage reset sources, sequences release through the oscillator
  stabilisation wait and keeps the registers that survive a reset.
  Assumes watchdog and clock-monitor requests come from clk-domain logic;
  the reset pin and the voltage comparator are asynchronous.
*/
`timescale 1ns/10ps
module system_reset_controller #(
  parameter int STAB_CYCLES = reset_ctrl_pkg::STAB_CYCLES_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic resetPin_n,
  input wire logic watchdogOverflowReq,
  input wire logic clockMonitorReq,
  input wire logic voltageLow,
  input wire logic cpuRamAccess,
  input wire logic [reset_ctrl_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [reset_ctrl_pkg::DATA_W-1:0] writedata,
  output logic [reset_ctrl_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  output logic sysReset_r,
  output logic mainOscEnable_r,
  output logic intOscEnable_r,
  output logic subOscEnable_r,
  output logic periphClkEnable_r,
  output logic cpuClkEnable_r,
  output logic [1:0] cpuClkDiv_r,
  output logic cpuRun_r,
  output logic watchdogClear_r,
  output logic watchdogRun_r,
  output logic portHighZ_r,
  output logic lowVoltageIrq_r,
  output logic debugModeEnable_r,
  output logic ramDataLost_r,
  output logic firmwareRamClaim_r
);
  import reset_ctrl_pkg::*;

  localparam logic [CNT_W-1:0] WDT_LAST = CNT_W'(WDT_RESET_CYCLES - 1);
  localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] syncIn;
  logic pinHigh;
  logic vLow;

  reset_input_sync #(
    .W(2),
    .RESET_VAL(2'h0)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn({voltageLow, resetPin_n}),
    .syncOut(syncIn)
  );
  assign pinHigh = syncIn[0];
  assign vLow = syncIn[1];

  ////////////////////////////////////////////////////////////////////////////
  // registers and sequencer state
  state_type state_r;
  state_type state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [7:0] wdtCtrl_r;
  logic [7:0] vdetMode_r;
  logic [7:0] srcFlags_r;
  logic [7:0] debugMode_r;
  logic powerOn_r;
  logic vLowPrev_r;
  logic wrAcc;
  logic rdAcc;
  logic inResetNxt;
  logic vdetResetSel;
  logic wdtReq;

  assign vdetResetSel = vdetMode_r[VDET_ENABLE_BIT] && vdetMode_r[VDET_SELECT_BIT];
  assign wdtReq = (watchdogOverflowReq && wdtCtrl_r[WDT_MODE_BIT]) || clockMonitorReq;
  assign inResetNxt = (state_nxt == ST_PIN) || (state_nxt == ST_WDT) || (state_nxt == ST_LVI);
  // request taken on the edge where waitrequest is seen low
  assign wrAcc = write && !waitrequest;
  assign rdAcc = read && !waitrequest;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN, ST_STAB: begin
        if (state_r == ST_STAB && cnt_r == STAB_LAST) begin
          state_nxt = ST_RUN;
        end
        if (state_r == ST_RUN && wdtReq) begin
          state_nxt = ST_WDT;
        end else if (vLow && vdetResetSel) begin
          state_nxt = ST_LVI;
        end
      end
      ST_WDT: begin
        if (cnt_r == WDT_LAST) begin
          state_nxt = ST_STAB;
        end
      end
      ST_LVI: begin
        if (!vLow || !vdetResetSel) begin
          state_nxt = ST_STAB;
        end
      end
      ST_PIN: begin
        if (pinHigh) begin
          state_nxt = ST_STAB;
        end
      end
      default: state_nxt = ST_PIN;
    endcase
    // pin low overrides every other source
    if (!pinHigh) begin
      state_nxt = ST_PIN;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_PIN;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + CNT_W'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock, cpu, watchdog and port controls
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysReset_r <= 1'b1;
      mainOscEnable_r <= 1'b0;
      intOscEnable_r <= 1'b0;
      subOscEnable_r <= 1'b1;
      periphClkEnable_r <= 1'b0;
      cpuClkEnable_r <= 1'b0;
      cpuRun_r <= 1'b0;
      watchdogClear_r <= 1'b1;
      watchdogRun_r <= 1'b0;
      portHighZ_r <= 1'b1;
    end else begin
      sysReset_r <= inResetNxt;
      mainOscEnable_r <= !inResetNxt;
      intOscEnable_r <= !inResetNxt;
      subOscEnable_r <= 1'b1;
      periphClkEnable_r <= (state_nxt == ST_RUN);
      cpuClkEnable_r <= (state_nxt == ST_RUN);
      cpuRun_r <= (state_nxt == ST_RUN);
      watchdogClear_r <= inResetNxt;
      watchdogRun_r <= !inResetNxt;
      portHighZ_r <= inResetNxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // peripheral registers: watchdog control initialised by every reset and held through stabilisation, the others initialised by pin reset only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdtCtrl_r <= {5'h00, CPU_DIV_RESET, 1'b0};
    end else if (inResetNxt || state_nxt == ST_STAB) begin
      wdtCtrl_r <= {5'h00, CPU_DIV_RESET, 1'b0};
    end else if (wrAcc && address == OFS_WDT_CTRL) begin
      wdtCtrl_r <= {5'h00, writedata[2:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuClkDiv_r <= CPU_DIV_RESET;
    end else begin
      cpuClkDiv_r <= wdtCtrl_r[CPU_DIV_LSB +: 2];
    end
  end

  // detector mode survives its own reset, else the reset could never hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vdetMode_r <= 8'h00;
    end else if (state_nxt == ST_PIN) begin
      vdetMode_r <= 8'h00;
    end else if (wrAcc && address == OFS_VDET_MODE) begin
      vdetMode_r <= {writedata[7], 6'h00, writedata[0]};
    end
  end

  // source flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srcFlags_r <= SRC_FLAGS_RESET;
    end else if (state_nxt == ST_PIN) begin
      srcFlags_r <= SRC_FLAGS_RESET;
    end else begin
      if (wrAcc && address == OFS_SRC_FLAGS) begin
        srcFlags_r <= writedata[7:0] & 8'h13;
      end
      if (state_r != ST_WDT && state_nxt == ST_WDT) begin
        if (clockMonitorReq) begin
          srcFlags_r[FLAG_CLKMON_BIT] <= 1'b1;
        end else begin
          srcFlags_r[FLAG_WDT_BIT] <= 1'b1;
        end
      end
      if (state_r != ST_LVI && state_nxt == ST_LVI) begin
        srcFlags_r[FLAG_VDET_BIT] <= 1'b1;
      end
    end
  end

  // debug mode register: set by pin reset, kept by the other resets
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      debugMode_r <= DEBUG_MODE_RESET;
      debugModeEnable_r <= 1'b1;
    end else begin
      if (state_nxt == ST_PIN) begin
        debugMode_r <= DEBUG_MODE_RESET;
      end else if (wrAcc && address == OFS_DEBUG_MODE) begin
        debugMode_r <= {7'h00, writedata[0]};
      end
      debugModeEnable_r <= debugMode_r[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ram state, power-on marker and low-voltage interrupt
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      powerOn_r <= 1'b1;
      ramDataLost_r <= 1'b1;
      firmwareRamClaim_r <= 1'b1;
    end else begin
      if (wrAcc && address == OFS_STATUS && writedata[ST_POWERON_BIT]) begin
        powerOn_r <= 1'b0;
      end
      // data damaged when a cpu access meets reset assertion
      if (!sysReset_r && inResetNxt && cpuRamAccess) begin
        ramDataLost_r <= 1'b1;
      end else if (wrAcc && address == OFS_STATUS && writedata[ST_RAMLOST_BIT]) begin
        ramDataLost_r <= 1'b0;
      end
      firmwareRamClaim_r <= powerOn_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vLowPrev_r <= 1'b0;
      lowVoltageIrq_r <= 1'b0;
    end else begin
      vLowPrev_r <= vLow;
      lowVoltageIrq_r <= vLow && !vLowPrev_r && vdetMode_r[VDET_ENABLE_BIT]
                         && !vdetMode_r[VDET_SELECT_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, then data and release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata <= '0;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest) begin
        if (address == OFS_WDT_CTRL) begin
          readdata <= {24'h000000, wdtCtrl_r};
        end else if (address == OFS_VDET_MODE) begin
          readdata <= {24'h000000, vdetMode_r};
        end else if (address == OFS_SRC_FLAGS) begin
          readdata <= {24'h000000, srcFlags_r};
        end else if (address == OFS_DEBUG_MODE) begin
          readdata <= {24'h000000, debugMode_r};
        end else if (address == OFS_STATUS) begin
          readdata <= {27'h0000000, vLow, ramDataLost_r, powerOn_r, cpuRun_r, sysReset_r};
        end else begin
          readdata <= '0;
        end
      end else if (rdAcc) begin
        readdata <= readdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  sequence sWdtEnd;
    state_r == ST_WDT && cnt_r == WDT_LAST && pinHigh;
  endsequence

  sequence sStabEnd;
    state_r == ST_STAB && cnt_r == STAB_LAST && pinHigh && !(vLow && vdetResetSel);
  endsequence

  // release follows the very next synced high sample, so only the cycle after is held
  a_pin_holds_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !pinHigh |=> sysReset_r && state_r == ST_PIN && portHighZ_r && !cpuRun_r)
    else $error("pin low did not hold reset");

  a_wdt_fixed_release: assert property (@(posedge clk) disable iff (!rst_n)
    sWdtEnd |=> state_r == ST_STAB && !sysReset_r && !cpuRun_r)
    else $error("watchdog reset not released after fixed delay");

  a_wdt_enter_reset: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_RUN && pinHigh && watchdogOverflowReq && wdtCtrl_r[WDT_MODE_BIT]
    |=> sysReset_r [*2])
    else $error("watchdog overflow did not reset");

  a_osc_stopped: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == ST_WDT || state_r == ST_LVI) |-> !mainOscEnable_r && !intOscEnable_r)
    else $error("main oscillator running during reset");

  a_vdet_no_reset: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_RUN && pinHigh && !wdtReq && !vdetMode_r[VDET_SELECT_BIT]
    |=> state_r != ST_LVI)
    else $error("low voltage reset with select bit clear");

  a_vdet_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_LVI && vLow && vdetResetSel && pinHigh |=> sysReset_r && state_r == ST_LVI)
    else $error("low voltage reset released early");

  a_vdet_irq: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(vLow) && vdetMode_r[VDET_ENABLE_BIT] && !vdetMode_r[VDET_SELECT_BIT]
    |=> lowVoltageIrq_r ##1 !lowVoltageIrq_r)
    else $error("low voltage interrupt missing");

  a_cpu_start_div8: assert property (@(posedge clk) disable iff (!rst_n)
    sStabEnd |=> cpuRun_r && cpuClkEnable_r && periphClkEnable_r
    && cpuClkDiv_r == CPU_DIV_RESET)
    else $error("cpu did not start at divide by eight");

  a_stab_wait: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cpuRun_r) |-> $past(state_r) == ST_STAB && $past(cnt_r) == STAB_LAST)
    else $error("cpu started before stabilisation time");

  a_wdt_cleared: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(sysReset_r) |-> watchdogRun_r && !watchdogClear_r && $past(watchdogClear_r))
    else $error("watchdog not cleared or not restarted");

  a_pin_clears_flags: assert property (@(posedge clk) disable iff (!rst_n)
    state_r == ST_PIN |-> srcFlags_r == SRC_FLAGS_RESET && debugMode_r == DEBUG_MODE_RESET)
    else $error("pin reset left flags or debug mode");

endmodule : system_reset_controller

/* File: testbench/reset_source_model.sv */
/*
  Far-side model of the reset sources: external reset pin, watchdog overflow
  request, voltage comparator and clock monitor.
  Assumes the bench changes its commands by non-blocking assignment just after
  a rising clock edge; each output registers its command, resetPin_n as its inverse.
*/
`timescale 1ns/10ps
module reset_source_model (
  input wire logic clk,
  input wire logic pinAssert,
  input wire logic wdtOverflow,
  input wire logic supplyDrop,
  input wire logic clockStop,
  output logic resetPin_n = 1'b1,
  output logic watchdogOverflowReq = 1'b0,
  output logic voltageLow = 1'b0,
  output logic clockMonitorReq = 1'b0
);
  ////////////////////////////////////////////////////////////////////////////
  // pin held low as long as the party wants reset
  always @(posedge clk) begin
    resetPin_n <= ~pinAssert;
  end

  ////////////////////////////////////////////////////////////////////////////
  // request levels, held by the bench until the reset is seen
  always @(posedge clk) begin
    watchdogOverflowReq <= wdtOverflow;
    voltageLow <= supplyDrop;
    clockMonitorReq <= clockStop;
  end
endmodule : reset_source_model

/* File: testbench/system_reset_controller_tb_top.sv */
/*
  Self-checking bench of the system reset controller.
  Assumes a 250 MHz clock, a shortened stabilisation count and an
  Avalon-MM master that holds each request until waitrequest is low.
*/
`timescale 1ns/10ps
module system_reset_controller_tb_top;
  import reset_ctrl_pkg::*;
  localparam int STAB = 16;
  localparam logic [9:0] VIEW_RST = 10'b1001000101;
  localparam logic [9:0] VIEW_RUN = 10'b0111111010;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cpuRamAccess = 1'b0;
  logic [ADDR_W-1:0] address = '0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [DATA_W-1:0] writedata = '0;
  logic pinAssert = 1'b0;
  logic wdtOverflow = 1'b0;
  logic supplyDrop = 1'b0;
  logic clockStop = 1'b0;
  logic resetPin_n, watchdogOverflowReq, voltageLow, clockMonitorReq;
  logic [DATA_W-1:0] readdata;
  logic waitrequest, sysReset_r, mainOscEnable_r, intOscEnable_r, subOscEnable_r;
  logic periphClkEnable_r, cpuClkEnable_r, cpuRun_r, watchdogClear_r, watchdogRun_r;
  logic portHighZ_r, lowVoltageIrq_r, debugModeEnable_r, ramDataLost_r, firmwareRamClaim_r;
  logic [1:0] cpuClkDiv_r;
  logic [9:0] view;
  int numErrors = 0;
  int checkCount = 0;

  assign view = {sysReset_r, mainOscEnable_r, intOscEnable_r, subOscEnable_r,
    periphClkEnable_r, cpuClkEnable_r, cpuRun_r, watchdogClear_r, watchdogRun_r, portHighZ_r};

  always #2 clk = ~clk;

  system_reset_controller #(.STAB_CYCLES(STAB)) i_dut (
    .clk(clk), .rst_n(rst_n), .resetPin_n(resetPin_n),
    .watchdogOverflowReq(watchdogOverflowReq), .clockMonitorReq(clockMonitorReq),
    .voltageLow(voltageLow), .cpuRamAccess(cpuRamAccess), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sysReset_r(sysReset_r), .mainOscEnable_r(mainOscEnable_r),
    .intOscEnable_r(intOscEnable_r), .subOscEnable_r(subOscEnable_r),
    .periphClkEnable_r(periphClkEnable_r), .cpuClkEnable_r(cpuClkEnable_r),
    .cpuClkDiv_r(cpuClkDiv_r), .cpuRun_r(cpuRun_r), .watchdogClear_r(watchdogClear_r),
    .watchdogRun_r(watchdogRun_r), .portHighZ_r(portHighZ_r),
    .lowVoltageIrq_r(lowVoltageIrq_r), .debugModeEnable_r(debugModeEnable_r),
    .ramDataLost_r(ramDataLost_r), .firmwareRamClaim_r(firmwareRamClaim_r)
  );

  reset_source_model i_src (
    .clk(clk), .pinAssert(pinAssert), .wdtOverflow(wdtOverflow), .supplyDrop(supplyDrop),
    .clockStop(clockStop), .resetPin_n(resetPin_n), .watchdogOverflowReq(watchdogOverflowReq),
    .voltageLow(voltageLow), .clockMonitorReq(clockMonitorReq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // values taken at the edge where waitrequest is seen low
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    d = readdata;
    read <= 1'b0;
  endtask : bus_read

  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= 1'b1;
    do @(posedge clk); while (waitrequest !== 1'b0);
    write <= 1'b0;
  endtask : bus_write

  task automatic wait_reset(output int n);
    n = 0;
    while (sysReset_r !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_reset

  task automatic wait_run(output int n);
    n = 0;
    while (cpuRun_r !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_run

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_power_on;
    int n;
    logic [31:0] d;
    wait_run(n);
    check("stab wait", 32'(n >= STAB), 32'h1);
    check("run outputs", 32'(view), 32'(VIEW_RUN));
    check("ram lost", 32'(ramDataLost_r), 32'h1);
    check("firmware ram", 32'(firmwareRamClaim_r), 32'h1);
    check("debug enable", 32'(debugModeEnable_r), 32'h1);
    bus_read(OFS_SRC_FLAGS, d);
    check("flags", d, 32'h0);
    bus_write(OFS_STATUS, 32'h0000_000c);
    repeat (2) @(posedge clk);
    check("ram lost cleared", 32'(ramDataLost_r), 32'h0);
    bus_read(OFS_STATUS, d);
    check("status", d, 32'h2);
  endtask : test_power_on

  task automatic test_wdt;
    int n;
    logic [31:0] d;
    bus_write(OFS_DEBUG_MODE, 32'h0);
    bus_write(OFS_WDT_CTRL, 32'h0);
    wdtOverflow <= 1'b1;
    repeat (6) @(posedge clk);
    wdtOverflow <= 1'b0;
    check("wdt ignored", 32'(sysReset_r), 32'h0);
    repeat (2) @(posedge clk);
    bus_write(OFS_WDT_CTRL, 32'h1);
    repeat (2) @(posedge clk);
    check("div written", 32'(cpuClkDiv_r), 32'h0);
    wdtOverflow <= 1'b1;
    wait_reset(n);
    wdtOverflow <= 1'b0;
    check("wdt reset", 32'(n <= 8), 32'h1);
    repeat (2) @(posedge clk);
    check("wdt reset outputs", 32'(view), 32'(VIEW_RST));
    wait_run(n);
    // one reset delay plus one stabilisation wait, less the edges seen above
    check("wdt hold", 32'(n + 4 >= WDT_RESET_CYCLES + STAB), 32'h1);
    check("wdt run outputs", 32'(view), 32'(VIEW_RUN));
    check("div reset", 32'(cpuClkDiv_r), 32'(CPU_DIV_RESET));
    check("debug kept", 32'(debugModeEnable_r), 32'h0);
    check("ram kept", 32'(ramDataLost_r), 32'h0);
    check("firmware ram kept", 32'(firmwareRamClaim_r), 32'h0);
    bus_read(OFS_SRC_FLAGS, d);
    check("wdt flag", d, 32'h10);
    bus_write(OFS_SRC_FLAGS, 32'h0);
  endtask : test_wdt

  task automatic test_lvi_reset;
    int n;
    logic [31:0] d;
    bus_write(OFS_VDET_MODE, 32'h81);
    cpuRamAccess <= 1'b1;
    supplyDrop <= 1'b1;
    wait_reset(n);
    cpuRamAccess <= 1'b0;
    check("lvi reset", 32'(n <= 10), 32'h1);
    repeat (100) @(posedge clk);
    check("lvi hold", 32'(view), 32'(VIEW_RST));
    supplyDrop <= 1'b0;
    wait_run(n);
    check("lvi release", 32'(view), 32'(VIEW_RUN));
    check("ram collision", 32'(ramDataLost_r), 32'h1);
    bus_read(OFS_SRC_FLAGS, d);
    check("lvi flag", d, 32'h01);
  endtask : test_lvi_reset

  // enabled with select 0 gives one interrupt; disabled gives nothing
  task automatic test_lvi_irq;
    logic [31:0] modes [2] = '{32'h80, 32'h01};
    int pulses [2] = '{1, 0};
    int p;
    int r;
    for (int k = 0; k < 2; k++) begin
      bus_write(OFS_VDET_MODE, modes[k]);
      supplyDrop <= 1'b1;
      p = 0;
      r = 0;
      repeat (12) begin
        @(posedge clk);
        p += int'(lowVoltageIrq_r === 1'b1);
        r += int'(sysReset_r !== 1'b0);
      end
      supplyDrop <= 1'b0;
      repeat (8) @(posedge clk);
      check("irq pulses", 32'(p), 32'(pulses[k]));
      check("no lvi reset", 32'(r), 32'h0);
    end
  endtask : test_lvi_irq

  task automatic test_pin_and_clkmon;
    int n;
    logic [31:0] d;
    pinAssert <= 1'b1;
    wait_reset(n);
    check("pin reset", 32'(n <= 10), 32'h1);
    repeat (20) @(posedge clk);
    check("pin hold", 32'(view), 32'(VIEW_RST));
    pinAssert <= 1'b0;
    wait_run(n);
    check("pin stab", 32'(n >= STAB), 32'h1);
    check("debug set", 32'(debugModeEnable_r), 32'h1);
    bus_read(OFS_SRC_FLAGS, d);
    check("pin flags", d, 32'h0);
    bus_write(OFS_DEBUG_MODE, 32'h0);
    repeat (2) @(posedge clk);
    check("debug cleared", 32'(debugModeEnable_r), 32'h0);
    clockStop <= 1'b1;
    wait_reset(n);
    clockStop <= 1'b0;
    wait_run(n);
    bus_read(OFS_SRC_FLAGS, d);
    check("clkmon flag", d, 32'h02);
    bus_read(8'h20, d);
    check("unmapped", d, 32'h0);
  endtask : test_pin_and_clkmon

  ////////////////////////////////////////////////////////////////////////////
  // sequence, watchdog and verdict
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checkCount, numErrors);
    if (numErrors == 0 && checkCount > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5) @(posedge clk);
    check("power-on outputs", 32'(view), 32'(VIEW_RST));
    check("power-on div", 32'(cpuClkDiv_r), 32'(CPU_DIV_RESET));
    rst_n <= 1'b1;
    test_power_on();
    test_wdt();
    test_lvi_reset();
    test_lvi_irq();
    test_pin_and_clkmon();
    tally_and_finish();
  end

  // whole run is well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    numErrors++;
    tally_and_finish();
  end
endmodule : system_reset_controller_tb_top
